//--- dv/low_power_mode_controller_test.sv
// testbench of the low power mode controller
`timescale 1ns/1ns
module low_power_mode_controller_test;
	import lpm_pkg::*;
	logic core_clk = 0, rst_b = 0, sel = 0;
	lpm_req_t cpu_req = LPM_REQ_NONE;
	logic [2:0] kind = 0;
	logic [3:0] line = 0;
	wire pe, vd, al, wp, rb, wd;
	wire [15:0] el;
	lpm_ctrl_t ctrl;
	lpm_aon_t aon;
	lpm_state_t state;
	logic sf, wk;
	int failures = 0, comparisons = 0, cyc = 0, q[$];
	byte ks[12] = '{7, 1, 4, 7, 2, 5, 7, 3, 6, 7, 1, 3};
	initial forever #2 core_clk = ~core_clk;
	lpm_wake_src i_src(.kind(kind), .line(line), .periph_event(pe), .ext_lines(el), .volt_det(vd),
		.alarm(al), .wake_pin(wp), .rst_pin_b(rb), .wdg_rst(wd));
	lpm_ctrl #(.RST_HOLD(2)) i_dut(.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1), .cpu_req(cpu_req),
		.regulator_low_power_sel(sel), .periph_event(pe), .external_interrupt_lines(el),
		.supply_voltage_detector_output(vd), .rtc_alarm(al), .wakeup_pin(wp), .external_reset_pin_b(rb),
		.independent_watchdog_reset(wd), .ctrl(ctrl), .aon(aon), .state(state), .standby_flag(sf),
		.wake_pulse(wk));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		if (failures == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	function automatic logic [7:0] exp_ctrl(int m, logic s);
		case (m)
			1: return 8'h7D;
			2: return {6'h01, s, 1'b1};
			3: return 8'h00;
			default: return 8'hFD;
		endcase
	endfunction
	// one request, a refused source in sleep and stop only, then the wake
	task go(input int m, input int k);
		int n;
		@(posedge core_clk) cpu_req <= lpm_req_t'(m);
		sel <= 1'($urandom);
		line <= 4'($urandom);
		q.push_back(m);
		@(posedge core_clk) cpu_req <= LPM_REQ_NONE;
		repeat (2) @(posedge core_clk);
		#1 m = q.pop_front();
		check({3'h0, state}, 8'(5'h01 << m));
		check(ctrl & (m == 3 ? 8'hFD : 8'hFF), exp_ctrl(m, sel));
		if (m != 3)
		begin
			@(posedge core_clk) kind <= (m == 1) ? 3'h4 : 3'h5;
			repeat (6) @(posedge core_clk);
			#1 check({3'h0, state}, 8'(5'h01 << m));
			@(posedge core_clk) kind <= 0;
		end
		@(posedge core_clk) kind <= 3'(k);
		n = 0;
		while (wk !== 1'b1 && n < 40)
		begin
			@(posedge core_clk);
			#1 n++;
		end
		check({7'h0, wk}, 8'h01);
		// ctrl trails the return to run by one cycle
		@(posedge core_clk) kind <= 0;
		#1 check(ctrl, 8'hFD);
		check({7'h0, sf}, 8'(m == 3));
	endtask
	always @(posedge core_clk)
		if (++cyc == 4000)
		begin
			failures++;
			give_verdict;
		end
	initial
	begin
		void'($urandom(32'hFEEF));
		repeat (6) @(posedge core_clk);
		rst_b <= 1;
		#1 check(ctrl, 8'hFD);
		for (int i = 0; i < 12; i++) go(i % 3 + 1, ks[i]);
		give_verdict;
	end
endmodule // low_power_mode_controller_test
bind lpm_ctrl lpm_ctrl_properties i_prop(.*);

//--- dv/lpm_ctrl_properties.sv
// assertions of the low power mode controller
`timescale 1ns/1ns
module lpm_ctrl_properties
	import lpm_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        periph_event,
	input wire logic [15:0] external_interrupt_lines,
	input wire logic        regulator_low_power_sel,
	input wire logic        external_reset_pin_b,
	input wire lpm_ctrl_t   ctrl,
	input wire lpm_aon_t    aon,
	input wire lpm_state_t  state
);
	// ctrl trails state by one cycle, so only settled states are judged
	lpm_state_t ps_q;
	always_ff @(posedge core_clk) ps_q <= state;
	wire stay = state == ps_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	AST_SLEEP: assert property (state == LPM_SLEEP && stay |-> ctrl == 8'h7D) else $error("sleep ctrl");
	AST_SLEEP_WAKE: assert property (state == LPM_SLEEP && periph_event |=> state == LPM_RUN) else $error("no wake");
	AST_STOP: assert property (state == LPM_STOP && stay |-> ctrl[7:2] == 6'h01) else $error("stop ctrl");
	AST_REG: assert property ($rose(state == LPM_STOP) |=>
		ctrl.regulator_low_power == $past(regulator_low_power_sel)) else $error("reg mode");
	AST_STOP_WAKE: assert property (state == LPM_STOP && |external_interrupt_lines |->
		##[1:3] state == LPM_RUN) else $error("stop wake");
	AST_SBY: assert property (state == LPM_STANDBY && stay |-> ctrl[7:2] == 6'h00) else $error("standby ctrl");
	AST_SBY_WAKE: assert property (state == LPM_STANDBY && !external_reset_pin_b |->
		##[1:3] state == LPM_WAKERST) else $error("standby wake");
	AST_HOLD: assert property ($rose(state == LPM_WAKERST) |-> !ctrl.core_reset_b
		##0 (state == LPM_WAKERST)[*3] ##1 state == LPM_RUN) else $error("reset hold");
	AST_AON: assert property (aon == 3'h7) else $error("aon off");
	cover property (state == LPM_SLEEP);
	cover property (state == LPM_STOP);
	cover property (state == LPM_WAKERST);
endmodule // lpm_ctrl_properties

//--- dv/lpm_wake_src.sv
// wakeup event sources facing the controller
`timescale 1ns/1ns
module lpm_wake_src (
	input wire logic [2:0] kind,
	input wire logic [3:0] line,
	output logic           periph_event,
	output logic [15:0]    ext_lines,
	output logic           volt_det,
	output logic           alarm,
	output logic           wake_pin,
	output logic           rst_pin_b,
	output logic           wdg_rst
);
	assign periph_event = kind == 3'h7;
	assign ext_lines = {15'h0, kind == 3'h1} << line;
	assign volt_det = kind == 3'h2;
	assign alarm = kind == 3'h3;
	assign wake_pin = kind == 3'h4;
	assign rst_pin_b = kind != 3'h5;
	assign wdg_rst = kind == 3'h6;
endmodule // lpm_wake_src

//--- rtl/lpm_ctrl.sv
// low power mode controller: sleep, stop and standby sequencing with wakeup
//
// Contract
// - sleep gates only the processor clock; any peripheral event wakes it.
// - stop gates all core clocks and disables pll and both oscillators.
// - in stop, regulator may stay normal or go low-power as configured.
// - stop exits on any of 16 pin lines, voltage detector or alarm.
// - standby turns off regulator, pll and both high-speed oscillators.
// - after standby only backup and standby circuitry keep state.
// - standby exits on reset pin, watchdog reset, wakeup rising edge, alarm.
// - rtc, watchdog and their clock sources never stop in stop or standby.
`include "lpm_cfg.svh"
`timescale 1ns/1ns
module lpm_ctrl
	import lpm_pkg::*;
#(
	parameter int EXT_LINES = `LPM_EXT_LINES,
	parameter int RST_HOLD  = `LPM_RST_HOLD_CYC
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst_b,
	input  wire logic                 clk_en,
	input  wire lpm_req_t             cpu_req,
	input  wire logic                 regulator_low_power_sel,
	input  wire logic                 periph_event,
	input  wire logic [EXT_LINES-1:0] external_interrupt_lines,
	input  wire logic                 supply_voltage_detector_output,
	input  wire logic                 rtc_alarm,
	input  wire logic                 wakeup_pin,
	input  wire logic                 external_reset_pin_b,
	input  wire logic                 independent_watchdog_reset,
	output lpm_ctrl_t                 ctrl,
	output lpm_aon_t                  aon,
	output lpm_state_t                state,
	output logic                      standby_flag,
	output logic                      wake_pulse
);
	// ************************************************
	// input synchronisers
	// ************************************************
	localparam int SW = EXT_LINES + 5;
	logic [SW-1:0] raw_w;
	logic [SW-1:0] syn_w;

	assign raw_w = {external_interrupt_lines, supply_voltage_detector_output, rtc_alarm,
		wakeup_pin, external_reset_pin_b, independent_watchdog_reset};

	lpm_sync #(.W(SW)) u_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.async_in (raw_w),
		.sync_out (syn_w)
	);

	wire logic [EXT_LINES-1:0] ext_s  = syn_w[SW-1:5];
	wire logic                 pvd_s  = syn_w[4];
	wire logic                 alrm_s = syn_w[3];
	wire logic                 wkp_s  = syn_w[2];
	wire logic                 external_reset_pin_s = syn_w[1];
	wire logic                 independent_watchdog_s = syn_w[0];

	// ************************************************
	// wakeup decode
	// ************************************************
	logic wkp_prev_q;
	logic wkp_rise_w;
	logic stop_wake_w;
	logic stby_wake_w;
	logic sleep_wake_w;

	assign wkp_rise_w   = wkp_s & ~wkp_prev_q;
	assign stop_wake_w  = (|ext_s) | pvd_s | alrm_s;
	assign stby_wake_w  = ~external_reset_pin_s | independent_watchdog_s | wkp_rise_w | alrm_s;
	// any event seen by the stop path also counts as a peripheral event
	assign sleep_wake_w = periph_event | stop_wake_w;

	// ************************************************
	// state machine
	// ************************************************
	lpm_state_t          state_q;
	lpm_state_t          state_d;
	logic [15:0]         hold_q;
	logic [15:0]         hold_d;
	logic                stby_flag_q;
	logic                wake_d;
	logic                wake_q;
	logic                reg_lp_q;

	always_comb
	begin
		state_d = state_q;
		hold_d  = hold_q;
		wake_d  = 1'b0;
		unique case (state_q)
			LPM_RUN:
			begin
				if (cpu_req == LPM_REQ_SLEEP)
					state_d = LPM_SLEEP;
				else if (cpu_req == LPM_REQ_STOP)
					state_d = LPM_STOP;
				else if (cpu_req == LPM_REQ_STANDBY)
					state_d = LPM_STANDBY;
			end
			LPM_SLEEP:
				if (sleep_wake_w)
				begin
					state_d = LPM_RUN;
					wake_d  = 1'b1;
				end
			LPM_STOP:
				if (stop_wake_w)
				begin
					state_d = LPM_RUN;
					wake_d  = 1'b1;
				end
			LPM_STANDBY:
				if (stby_wake_w)
				begin
					state_d = LPM_WAKERST;
					hold_d  = 16'(RST_HOLD);
				end
			LPM_WAKERST:
				if (hold_q == 16'h0000)
				begin
					state_d = LPM_RUN;
					wake_d  = 1'b1;
				end
				else
					hold_d = hold_q - 16'h0001;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q     <= LPM_RUN;
			hold_q      <= 16'h0000;
			wkp_prev_q  <= 1'b0;
			stby_flag_q <= 1'b0;
			wake_q      <= 1'b0;
			reg_lp_q    <= 1'b0;
		end
		else if (clk_en)
		begin
			state_q    <= state_d;
			hold_q     <= hold_d;
			wkp_prev_q <= wkp_s;
			wake_q     <= wake_d;
			// selection latched at entry so a stuck core cannot change it later
			if (state_q == LPM_RUN && state_d == LPM_STOP)
				reg_lp_q <= regulator_low_power_sel;
			// standby circuitry keeps this flag; cleared by the next sleep or stop request
			if (state_d == LPM_STANDBY)
				stby_flag_q <= 1'b1;
			else if (state_q == LPM_RUN && cpu_req != LPM_REQ_NONE)
				stby_flag_q <= 1'b0;
		end
	end

	// ************************************************
	// power and clock controls
	// ************************************************
	wire logic in_stop_w = (state_q == LPM_STOP);
	wire logic in_stby_w = (state_q == LPM_STANDBY) | (state_q == LPM_WAKERST);
	wire logic osc_off_w = in_stop_w | in_stby_w;
	lpm_ctrl_t ctrl_d;

	always_comb
	begin
		ctrl_d.cpu_clk_en                     = (state_q == LPM_RUN);
		ctrl_d.core_clk_en                    = ~osc_off_w;
		ctrl_d.pll_en                         = ~osc_off_w;
		ctrl_d.internal_rc_oscillator_en      = ~osc_off_w;
		ctrl_d.external_crystal_oscillator_en = ~osc_off_w;
		ctrl_d.regulator_on                   = ~in_stby_w;
		ctrl_d.regulator_low_power            = in_stop_w & reg_lp_q;
		// core held in reset through standby, so lost state is rebuilt
		ctrl_d.core_reset_b                   = ~in_stby_w;
	end

	lpm_ctrl_t ctrl_q;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			ctrl_q <= lpm_ctrl_t'(8'hFD);
		else if (clk_en)
			ctrl_q <= ctrl_d;
	end

	assign ctrl         = ctrl_q;
	assign aon          = 3'h7;
	assign state        = state_q;
	assign standby_flag = stby_flag_q;
	assign wake_pulse   = wake_q;
endmodule // lpm_ctrl

//--- rtl/lpm_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ns
module lpm_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else if (clk_en)
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // lpm_sync

//--- shared/lpm_cfg.svh
// constants of the low power mode controller
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH
`define LPM_EXT_LINES       16
`define LPM_RST_HOLD_CYC    16
`define LPM_SYNC_W          20
`endif

//--- shared/lpm_pkg.sv
// types of the low power mode controller
package lpm_pkg;
	typedef enum logic [4:0] {
		LPM_RUN     = 5'h01,
		LPM_SLEEP   = 5'h02,
		LPM_STOP    = 5'h04,
		LPM_STANDBY = 5'h08,
		LPM_WAKERST = 5'h10
	} lpm_state_t;

	typedef enum logic [1:0] {
		LPM_REQ_NONE    = 2'h0,
		LPM_REQ_SLEEP   = 2'h1,
		LPM_REQ_STOP    = 2'h2,
		LPM_REQ_STANDBY = 2'h3
	} lpm_req_t;

	// power and clock controls toward the core domain
	typedef struct packed {
		logic cpu_clk_en;
		logic core_clk_en;
		logic pll_en;
		logic internal_rc_oscillator_en;
		logic external_crystal_oscillator_en;
		logic regulator_on;
		logic regulator_low_power;
		logic core_reset_b;
	} lpm_ctrl_t;

	// always-on units that must never be stopped
	typedef struct packed {
		logic rtc_clk_en;
		logic independent_watchdog_clk_en;
		logic low_speed_sources_en;
	} lpm_aon_t;
endpackage
